// file: design/stw_params.svh
`ifndef STW_PARAMS_SVH
`define STW_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define STW_IDX_SEC_INTERVAL 8'hF9
`define STW_IDX_MILLI_INTERVAL 8'hFA
`define STW_IDX_US_DIVIDER 8'hFB
`define STW_IDX_MS_DIV_LOW 8'hFC
`define STW_IDX_MS_DIV_HIGH 8'hFD
`define STW_IDX_HMS_DIVIDER 8'hFE
`define STW_IDX_WDOG_CONTROL 8'hFF
`define STW_IDX_AUX_IRQ_ENABLE 8'hA6
`define STW_IDX_HW_CONFIG_ZERO 8'h80
`define STW_IDX_IRQ_STATUS 8'h81
`define STW_IDX_IRQ_MASK 8'h82

// Field positions.
`define STW_LOAD_NOW_BIT 7
`define STW_WD_ENABLE_BIT 7
`define STW_WD_DISABLE_BIT 6
`define STW_WD_RESTART_BIT 5
`define STW_WD_SELECT_BIT 3
`define STW_AIE_SEC_BIT 7
`define STW_AIE_MS_BIT 4
`define STW_ST_MS_BIT 0
`define STW_ST_SEC_BIT 1
`define STW_ST_WD_BIT 2

// Reset values.
`define STW_RST_BYTE 8'h00
`define STW_RST_IVAL 7'h00
`define STW_RST_WD_FIELD 5'h00
`define STW_RST_FLAGS 3'h0

`endif

// file: design/stw_pkg.sv
package stw_pkg;

   typedef enum logic [3:0] {
      STW_R_NONE,
      STW_R_SEC_IVAL,
      STW_R_MSI_IVAL,
      STW_R_US_DIV,
      STW_R_MS_LO,
      STW_R_MS_HI,
      STW_R_HMS_DIV,
      STW_R_WD_CTL,
      STW_R_AIE,
      STW_R_HARDWARE_CONFIG_ZERO,
      STW_R_STAT,
      STW_R_MASK
   } stw_reg_e;

   typedef struct packed {
      logic [6:0] sec_ival;
      logic [6:0] msi_ival;
      logic [7:0] us_div;
      logic [7:0] ms_lo;
      logic [7:0] ms_hi;
      logic [7:0] hms_div;
      logic [4:0] wd_field;
      logic [2:0] wd_cmd;
      logic wd_rsel;
      logic aie_sec;
      logic aie_ms;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic [7:0] us_cnt;
      logic [15:0] ms_cnt;
      logic [7:0] hms_cnt;
      logic [6:0] sec_cnt;
      logic [6:0] msi_cnt;
      logic [5:0] wd_cnt;
      logic wd_en;
      logic resp;
      logic [31:0] rdata;
      logic slverr;
      logic irq;
      logic wd_rst;
      logic us_tick;
   } stw_state_s;

endpackage

// file: design/stw_timebase.sv
// Summary of operation
// - Microsecond counter reloads from its divider; tick every divider+1 clocks.
// - Millisecond counter reloads high*256+low; period is that value plus one.
// - Hundred-ms counter steps down on each millisecond wrap, reloading its divider at zero.
// - Seconds event every (sec+1)*(hms+1)*(ms+1) clocks, reloading at zero.
// - Seconds interval write with bit 7 set loads the counter at once.
// - Milliseconds event every (interval+1)*(ms reload+1) clocks.
// - Millisecond interval write with bit 7 set loads the counter at once.
// - Millisecond interval counter reloads from its register at zero.
// - Milliseconds interrupt is gated by enable bit 4.
// - Watchdog expires count+1 to count+2 hundred-ms periods after restart.
// - Write one then zero to bit 7, 6 or 5: enable, disable, restart.
// - Timeout resets the system unless select bit 3 asks for an interrupt.
//
// Added by the designer: the APB interface to the registers.

`include "stw_params.svh"

module stw_timebase
   import stw_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timebase events and watchdog outcome.
   output logic us_tick,
   output logic irq,
   output logic wdog_reset_req
);

   stw_state_s q;
   stw_state_s n;

   function automatic logic [11:0] stw_addr(input logic [7:0] idx);
      stw_addr = {2'b00, idx, 2'b00};
   endfunction

   function automatic stw_reg_e stw_decode(input logic [11:0] a);
      if (a == stw_addr(`STW_IDX_SEC_INTERVAL)) begin
         stw_decode = STW_R_SEC_IVAL;
      end else if (a == stw_addr(`STW_IDX_MILLI_INTERVAL)) begin
         stw_decode = STW_R_MSI_IVAL;
      end else if (a == stw_addr(`STW_IDX_US_DIVIDER)) begin
         stw_decode = STW_R_US_DIV;
      end else if (a == stw_addr(`STW_IDX_MS_DIV_LOW)) begin
         stw_decode = STW_R_MS_LO;
      end else if (a == stw_addr(`STW_IDX_MS_DIV_HIGH)) begin
         stw_decode = STW_R_MS_HI;
      end else if (a == stw_addr(`STW_IDX_HMS_DIVIDER)) begin
         stw_decode = STW_R_HMS_DIV;
      end else if (a == stw_addr(`STW_IDX_WDOG_CONTROL)) begin
         stw_decode = STW_R_WD_CTL;
      end else if (a == stw_addr(`STW_IDX_AUX_IRQ_ENABLE)) begin
         stw_decode = STW_R_AIE;
      end else if (a == stw_addr(`STW_IDX_HW_CONFIG_ZERO)) begin
         stw_decode = STW_R_HARDWARE_CONFIG_ZERO;
      end else if (a == stw_addr(`STW_IDX_IRQ_STATUS)) begin
         stw_decode = STW_R_STAT;
      end else if (a == stw_addr(`STW_IDX_IRQ_MASK)) begin
         stw_decode = STW_R_MASK;
      end else begin
         stw_decode = STW_R_NONE;
      end
   endfunction

   logic [15:0] ms_reload_value;
   logic ms_tick;
   logic hms_tick;
   logic sec_event;
   logic ms_event;
   logic wd_timeout;
   logic acc_first;
   logic acc_done;
   logic wr_done;
   stw_reg_e rsel;
   logic [7:0] wb;
   logic [7:0] rd_byte;
   logic [2:0] set_flags;
   logic [2:0] clr_flags;

   assign ms_reload_value = {q.ms_hi, q.ms_lo};
   assign ms_tick = (q.ms_cnt == 16'h0000);
   assign hms_tick = ms_tick && (q.hms_cnt == 8'h00);
   assign sec_event = hms_tick && (q.sec_cnt == 7'h00);
   assign ms_event = ms_tick && (q.msi_cnt == 7'h00);
   assign wd_timeout = q.wd_en && hms_tick && (q.wd_cnt == 6'h00);
   assign rsel = stw_decode(paddr);
   assign wb = pwdata[7:0];
   // The first access cycle only prepares the answer; the second ends it.
   // The extra wait state keeps every bus output straight from a flop.
   assign acc_first = psel && penable && !q.resp;
   assign acc_done = psel && penable && q.resp;
   assign wr_done = acc_done && pwrite && pstrb[0] && (rsel != STW_R_NONE);

   always_comb begin
      rd_byte = 8'h00;
      case (rsel)
         STW_R_SEC_IVAL: rd_byte = {1'b0, q.sec_ival};
         STW_R_MSI_IVAL: rd_byte = {1'b0, q.msi_ival};
         STW_R_US_DIV: rd_byte = q.us_div;
         STW_R_MS_LO: rd_byte = q.ms_lo;
         STW_R_MS_HI: rd_byte = q.ms_hi;
         STW_R_HMS_DIV: rd_byte = q.hms_div;
         STW_R_WD_CTL: rd_byte = {q.wd_cmd, q.wd_field};
         STW_R_AIE: begin
            rd_byte[`STW_AIE_SEC_BIT] = q.aie_sec;
            rd_byte[`STW_AIE_MS_BIT] = q.aie_ms;
         end
         STW_R_HARDWARE_CONFIG_ZERO: rd_byte[`STW_WD_SELECT_BIT] = q.wd_rsel;
         STW_R_STAT: rd_byte = {5'h00, q.irq_stat};
         STW_R_MASK: rd_byte = {5'h00, q.irq_mask};
         default: rd_byte = 8'h00;
      endcase
   end

   always_comb begin
      n = q;
      n.wd_rst = 1'b0;
      n.us_tick = 1'b0;
      set_flags = 3'h0;
      clr_flags = 3'h0;

      // Free-running divider chain.
      if (q.us_cnt == 8'h00) begin
         n.us_cnt = q.us_div;
         n.us_tick = 1'b1;
      end else begin
         n.us_cnt = q.us_cnt - 8'h01;
      end
      if (ms_tick) begin
         n.ms_cnt = ms_reload_value;
         if (q.hms_cnt == 8'h00) begin
            n.hms_cnt = q.hms_div;
         end else begin
            n.hms_cnt = q.hms_cnt - 8'h01;
         end
         if (q.msi_cnt == 7'h00) begin
            n.msi_cnt = q.msi_ival;
         end else begin
            n.msi_cnt = q.msi_cnt - 7'h01;
         end
      end else begin
         n.ms_cnt = q.ms_cnt - 16'h0001;
      end
      if (hms_tick) begin
         if (q.sec_cnt == 7'h00) begin
            n.sec_cnt = q.sec_ival;
         end else begin
            n.sec_cnt = q.sec_cnt - 7'h01;
         end
      end

      // Events only latch while their enable is set.
      set_flags[`STW_ST_MS_BIT] = ms_event && q.aie_ms;
      set_flags[`STW_ST_SEC_BIT] = sec_event && q.aie_sec;

      // Watchdog countdown in hundred-millisecond periods.
      if (q.wd_en && hms_tick) begin
         if (q.wd_cnt == 6'h00) begin
            n.wd_cnt = {1'b0, q.wd_field} + 6'h01;
         end else begin
            n.wd_cnt = q.wd_cnt - 6'h01;
         end
      end
      if (wd_timeout) begin
         if (q.wd_rsel) begin
            set_flags[`STW_ST_WD_BIT] = 1'b1;
         end else begin
            n.wd_rst = 1'b1;
         end
      end

      // Register writes take effect at the completing edge.
      if (wr_done) begin
         case (rsel)
            STW_R_SEC_IVAL: begin
               n.sec_ival = wb[6:0];
               if (wb[`STW_LOAD_NOW_BIT]) begin
                  n.sec_cnt = wb[6:0];
               end
            end
            STW_R_MSI_IVAL: begin
               n.msi_ival = wb[6:0];
               if (wb[`STW_LOAD_NOW_BIT]) begin
                  n.msi_cnt = wb[6:0];
               end
            end
            STW_R_US_DIV: n.us_div = wb;
            STW_R_MS_LO: n.ms_lo = wb;
            STW_R_MS_HI: n.ms_hi = wb;
            STW_R_HMS_DIV: n.hms_div = wb;
            STW_R_WD_CTL: begin
               n.wd_field = wb[4:0];
               n.wd_cmd = wb[7:5];
               // A command acts only on the falling half of 1-then-0.
               if (q.wd_cmd[2] && !wb[`STW_WD_ENABLE_BIT]) begin
                  n.wd_en = 1'b1;
                  n.wd_cnt = {1'b0, wb[4:0]} + 6'h01;
               end
               if (q.wd_cmd[1] && !wb[`STW_WD_DISABLE_BIT]) begin
                  n.wd_en = 1'b0;
               end
               if (q.wd_cmd[0] && !wb[`STW_WD_RESTART_BIT]) begin
                  n.wd_cnt = {1'b0, wb[4:0]} + 6'h01;
               end
            end
            STW_R_AIE: begin
               n.aie_sec = wb[`STW_AIE_SEC_BIT];
               n.aie_ms = wb[`STW_AIE_MS_BIT];
            end
            STW_R_HARDWARE_CONFIG_ZERO: n.wd_rsel = wb[`STW_WD_SELECT_BIT];
            STW_R_STAT: clr_flags = wb[2:0];
            STW_R_MASK: n.irq_mask = wb[2:0];
            default: n.irq_mask = q.irq_mask;
         endcase
      end

      // A new event in the clearing cycle keeps its flag set.
      n.irq_stat = (q.irq_stat & ~clr_flags) | set_flags;
      n.irq = |(n.irq_stat & n.irq_mask);

      // Bus answer.
      n.resp = acc_first;
      if (acc_first) begin
         n.rdata = {24'h000000, rd_byte};
         n.slverr = (rsel == STW_R_NONE);
      end else if (acc_done) begin
         n.rdata = 32'h00000000;
         n.slverr = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.sec_ival <= `STW_RST_IVAL;
         q.msi_ival <= `STW_RST_IVAL;
         q.us_div <= `STW_RST_BYTE;
         q.ms_lo <= `STW_RST_BYTE;
         q.ms_hi <= `STW_RST_BYTE;
         q.hms_div <= `STW_RST_BYTE;
         q.wd_field <= `STW_RST_WD_FIELD;
         q.wd_cmd <= `STW_RST_FLAGS;
         q.wd_rsel <= 1'b0;
         q.aie_sec <= 1'b0;
         q.aie_ms <= 1'b0;
         q.irq_stat <= `STW_RST_FLAGS;
         q.irq_mask <= `STW_RST_FLAGS;
         q.us_cnt <= `STW_RST_BYTE;
         q.ms_cnt <= 16'h0000;
         q.hms_cnt <= `STW_RST_BYTE;
         q.sec_cnt <= `STW_RST_IVAL;
         q.msi_cnt <= `STW_RST_IVAL;
         q.wd_cnt <= 6'h00;
         q.wd_en <= 1'b0;
         q.resp <= 1'b0;
         q.rdata <= 32'h00000000;
         q.slverr <= 1'b0;
         q.irq <= 1'b0;
         q.wd_rst <= 1'b0;
         q.us_tick <= 1'b0;
      end else begin
         q <= n;
      end
   end

   assign prdata = q.rdata;
   assign pready = q.resp;
   assign pslverr = q.slverr;
   assign us_tick = q.us_tick;
   assign irq = q.irq;
   assign wdog_reset_req = q.wd_rst;

endmodule

// file: verification/stw_timebase_asserts.sv
module stw_timebase_asserts (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Events.
   input wire logic us_tick,
   input wire logic irq,
   input wire logic wdog_reset_req
);
   logic hit;
   logic [1:0] q_q;
   logic [7:0] div_q;
   logic [7:0] gap_q;
   assign hit = paddr inside {12'h200, 12'h204, 12'h208, 12'h298,
      [12'h3E4:12'h3FC]};
   // A divider write restarts the measurement. The next two ticks still
   // close intervals begun on the old reload value, so both are skipped.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_q <= 2'h0;
         div_q <= 8'h00;
         gap_q <= 8'h00;
      end else begin
         gap_q <= us_tick ? 8'h00 : gap_q + 8'h01;
         if (psel && penable && pready && pwrite && pstrb[0] &&
               paddr == 12'h3EC) begin
            q_q <= 2'h0;
            div_q <= pwdata[7:0];
         end else if (us_tick && q_q != 2'h2) begin
            q_q <= q_q + 2'h1;
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("pready not after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero while idle");
   a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("prdata upper bits set");
   a_unmapped_err: assert property (pready && paddr[1:0] == 2'h0
      |-> pslverr == !hit) else $error("pslverr wrong for address");
   a_irq_hold: assert property ($fell(irq) |-> $past(pready && pwrite))
      else $error("irq fell without a register write");
   a_wd_pulse: assert property (wdog_reset_req |=> !wdog_reset_req)
      else $error("reset request longer than one cycle");
   a_tick_gap: assert property (us_tick && q_q == 2'h2 |-> gap_q == div_q)
      else $error("tick period differs from divider");
endmodule

bind stw_timebase stw_timebase_asserts chk_u (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .us_tick(us_tick), .irq(irq),
   .wdog_reset_req(wdog_reset_req));

// file: verification/stw_timebase_tb.sv
module stw_timebase_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [11:0] a; logic [7:0] d, x; logic e;} stw_row_s;
   typedef struct {logic [7:0] hi, lo, hm, mi, si, mk; int per;} stw_per_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic us_tick, irq, wdog_reset_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0] pstrb;
   int bad_count, tests_run, cyc, hits, n, h;
   stw_row_s rows [10] = '{'{12'h3E4, 8'h85, 8'h05, 1'b0},
      '{12'h3E8, 8'h81, 8'h01, 1'b0}, '{12'h3EC, 8'h04, 8'h04, 1'b0},
      '{12'h3F0, 8'h03, 8'h03, 1'b0}, '{12'h3F4, 8'h00, 8'h00, 1'b0},
      '{12'h3F8, 8'h01, 8'h01, 1'b0}, '{12'h200, 8'h08, 8'h08, 1'b0},
      '{12'h208, 8'h02, 8'h02, 1'b0}, '{12'h100, 8'h5A, 8'h00, 1'b1},
      '{12'h298, 8'h90, 8'h90, 1'b0}};
   stw_per_s pr [5] = '{'{8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01, 8},
      '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 257},
      '{8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h01, 6},
      '{8'h00, 8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 12},
      '{8'h00, 8'h02, 8'h00, 8'h00, 8'h01, 8'h02, 6}};
   stw_timebase dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .us_tick(us_tick), .irq(irq), .wdog_reset_req(wdog_reset_req));
   task automatic fail(input string m);
      bad_count++;
      tests_run++;
      $display("FAIL %0t %s", $time, m);
   endtask
   task automatic end_sim();
      if (bad_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [7:0] d, input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask
   // Status is cleared before each wait so that a stale flag is not
   // mistaken for the start of the measured period.
   task automatic gap(output int p);
      time t;
      wr(12'h204, 8'h07);
      do @(posedge pclk); while (irq !== 1'b1);
      t = $time;
      wr(12'h204, 8'h07);
      do @(posedge pclk); while (irq !== 1'b1);
      p = int'(($time - t) / 10);
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (wdog_reset_req === 1'b1) hits++;
      if (cyc == 20000) begin
         fail("timeout");
         end_sim();
      end
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 8'h00, 4'h0);
         if (r !== 32'h0) fail("reset value"); else tests_run++;
         wr(rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 8'h00, 4'h0);
         if (r[7:0] !== rows[i].x || e !== rows[i].e) fail("read");
         else tests_run++;
      end
      apb(1'b1, 12'h3EC, 8'h09, 4'h0);
      do @(posedge pclk); while (us_tick !== 1'b1);
      n = 0;
      do begin @(posedge pclk); n++; end while (us_tick !== 1'b1);
      if (n !== 4 + 1) fail("tick period"); else tests_run++;
      foreach (pr[i]) begin
         wr(12'h3F4, pr[i].hi);
         wr(12'h3F0, pr[i].lo);
         wr(12'h3F8, pr[i].hm);
         wr(12'h3E8, pr[i].mi | 8'h80);
         wr(12'h3E4, pr[i].si | 8'h80);
         wr(12'h208, pr[i].mk);
         gap(n);
         if (n !== pr[i].per) fail("period"); else tests_run++;
      end
      wr(12'h298, 8'h80);
      wr(12'h204, 8'h07);
      repeat (20) @(posedge pclk);
      apb(1'b0, 12'h204, 8'h00, 4'h0);
      if (r[1:0] !== 2'b10) fail("gate"); else tests_run++;
      wr(12'h208, 8'h00);
      @(posedge pclk);
      if (irq !== 1'b0) fail("mask"); else tests_run++;
      wr(12'h3F0, 8'h01);
      wr(12'h3F8, 8'h01);
      wr(12'h200, 8'h00);
      wr(12'h3FC, 8'h82);
      wr(12'h3FC, 8'h02);
      n = 0;
      while (wdog_reset_req !== 1'b1 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      if (n < 10 || n > 17) fail("wd time"); else tests_run++;
      // The hit counter updates on the same edge that ended the wait, so
      // it is read only after a whole transfer has let it settle.
      wr(12'h3FC, 8'h22);
      h = hits;
      wr(12'h3FC, 8'h02);
      repeat (5) begin
         wr(12'h3FC, 8'h22);
         wr(12'h3FC, 8'h02);
      end
      wr(12'h3FC, 8'h42);
      wr(12'h3FC, 8'h02);
      repeat (40) @(posedge pclk);
      if (hits !== h) fail("wd restart"); else tests_run++;
      wr(12'h200, 8'h08);
      wr(12'h208, 8'h04);
      wr(12'h204, 8'h07);
      wr(12'h3FC, 8'h82);
      wr(12'h3FC, 8'h02);
      repeat (20) @(posedge pclk);
      if (irq !== 1'b1 || hits !== h) fail("wd irq"); else tests_run++;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      if (irq !== 1'b0) fail("irq reset"); else tests_run++;
      apb(1'b0, 12'h3EC, 8'h00, 4'h0);
      if (r !== 32'h0) fail("divider reset"); else tests_run++;
      end_sim();
   end
endmodule
